// ===== inc/prs_pkg.sv
// Constants for the power-on reset sequencer.
// Assumes a single 25 MHz clock and an APB register port.
// Functional notes
// - Power-good high lets the block leave reset; low means supplies are not yet good.
// - System reset goes low at once when power-on sense is low and stays low meanwhile.
// - After power-on sense rises, system reset stays low until firmware releases it.
// - System reset asserts about 5 us after a power-good event or internal reset, for at least 2 ms.
// - Controller reset goes low with power-on sense and stays low until firmware releases it.
// - Controller reset on a power-good event or internal reset is optional, 5 us delay, 2 ms least.
// - Front-end reset goes low with power-on sense and stays low while it is low.
// - After power-on sense rises, front-end reset stays low until software releases it.
// - Front-end reset also asserts on those events and lasts 2 ms past software release.
// - A software control bit drives the front-end reset independently.
// - The front-end interrupt input is active high and reads inactive when undriven; the code adds no pull-down and samples an undriven input as it is.
package prs_pkg;
   localparam int CLK_HZ = 25000000;
   localparam int DELAY_NS = 5000;
   localparam int HOLD_US = 2000;
   localparam int DELAY_CYC = (DELAY_NS * (CLK_HZ / 1000000)) / 1000;
   localparam int HOLD_CYC = HOLD_US * (CLK_HZ / 1000000);
   localparam int CNT_W = 16;
   localparam logic [11:0] OFS_CTRL = 12'h0_000;
   localparam logic [11:0] OFS_STAT = 12'h0_004;
   localparam logic [11:0] OFS_EVENT = 12'h0_008;
   localparam int CTRL_SYS_REL = 0;
   localparam int CTRL_CTL_REL = 1;
   localparam int CTRL_FE_REL = 2;
   localparam int CTRL_CTL_AUTO = 3;
   localparam int CTRL_FE_FORCE = 4;
   localparam logic [4:0] CTRL_RESET = 5'h0_008;
   localparam int EVT_INTERNAL = 0;
endpackage : prs_pkg

// ===== rtl/prs_timer.sv
// Delay-then-hold timer for one reset output.
// Assumes trigger pulses and a release level synchronous to pclk.
`timescale 1ns/1ns
`default_nettype none
module prs_timer #(
   parameter int DELAY = prs_pkg::DELAY_CYC,
   parameter int HOLD = prs_pkg::HOLD_CYC
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic trig,
   input wire logic hold_more,
   output logic active
);
   import prs_pkg::*;
   typedef enum logic [2:0] {
      PRS_IDLE = 3'b001,
      PRS_WAIT = 3'b010,
      PRS_HOLD = 3'b100
   } prs_tstate_e;
   typedef struct packed {
      prs_tstate_e st;
      logic [CNT_W-1:0] cnt;
   } prs_timer_s;
   prs_timer_s s_reg;
   prs_timer_s s_next;
   always_comb
   begin
      s_next = s_reg;
      case (s_reg.st)
         PRS_IDLE:
         begin
            if (trig)
            begin
               s_next.st = PRS_WAIT;
               s_next.cnt = CNT_W'(DELAY - 1);
            end
         end
         PRS_WAIT:
         begin
            if (s_reg.cnt == '0)
            begin
               s_next.st = PRS_HOLD;
               s_next.cnt = CNT_W'(HOLD - 1);
            end
            else
               s_next.cnt = s_reg.cnt - 1'b1;
         end
         PRS_HOLD:
         begin
            // The hold restarts while the release is withheld.
            if (hold_more)
               s_next.cnt = CNT_W'(HOLD - 1);
            else if (s_reg.cnt == '0)
               s_next.st = PRS_IDLE;
            else
               s_next.cnt = s_reg.cnt - 1'b1;
         end
         default:
            s_next.st = PRS_IDLE;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_reg.st <= PRS_IDLE;
         s_reg.cnt <= '0;
      end
      else
         s_reg <= s_next;
   end
   assign active = (s_reg.st == PRS_HOLD);
endmodule : prs_timer
`default_nettype wire

// ===== rtl/prs_sequencer.sv
// Power-on reset sequencer with APB registers.
// Assumes inputs already synchronous to pclk, single 25 MHz clock.
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module prs_sequencer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic power_on_sense,
   input wire logic power_good_in,
   input wire logic frontend_irq_in,
   output logic system_reset_out_n,
   output logic controller_reset_out_n,
   output logic frontend_reset_out_n
);
   import prs_pkg::*;
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [1:0] pos_sync;
      logic [1:0] pg_sync;
      logic [1:0] irq_sync;
      logic pg_prev;
      logic [4:0] ctrl;
      logic [31:0] rdata;
   } prs_seq_s;
   prs_seq_s s_reg;
   prs_seq_s s_next;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic pos_low;
   logic pg_rise;
   logic int_evt;
   logic evt;
   logic sys_t;
   logic ctl_t;
   logic fe_t;
   function automatic logic is_reg(input logic [11:0] a);
      is_reg = (a == OFS_CTRL) || (a == OFS_STAT) || (a == OFS_EVENT);
   endfunction : is_reg
   assign addr_ok = is_reg(paddr);
   assign wr_en = psel && penable && pwrite && addr_ok;
   assign rd_en = psel && !penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_ok;
   assign pos_low = !s_reg.pos_sync[1];
   // Only a rising power-good counts as an event; low keeps all in reset.
   assign pg_rise = s_reg.pg_sync[1] && !s_reg.pg_prev;
   assign int_evt = wr_en && (paddr == OFS_EVENT) && pwdata[EVT_INTERNAL];
   assign evt = pg_rise || int_evt;
   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb
   begin
      s_next = s_reg;
      s_next.pos_sync = {s_reg.pos_sync[0], power_on_sense};
      s_next.pg_sync = {s_reg.pg_sync[0], power_good_in};
      s_next.irq_sync = {s_reg.irq_sync[0], frontend_irq_in};
      s_next.pg_prev = s_reg.pg_sync[1];
      if (wr_en && paddr == OFS_CTRL)
         s_next.ctrl = pwdata[4:0];
      // Power-on sense low or power-good low revokes every release.
      if (pos_low || !s_reg.pg_sync[1])
      begin
         s_next.ctrl[CTRL_SYS_REL] = 1'b0;
         s_next.ctrl[CTRL_CTL_REL] = 1'b0;
         s_next.ctrl[CTRL_FE_REL] = 1'b0;
      end
      // An event revokes only the front-end release; the other outputs
      // follow their timers, so system reset, and controller reset with CTRL_CTL_AUTO set, fall after the delay and not at once.
      if (evt)
         s_next.ctrl[CTRL_FE_REL] = 1'b0;
      s_next.rdata = '0;
      if (rd_en)
      begin
         case (paddr)
            OFS_CTRL: s_next.rdata = {27'h000_0000, s_reg.ctrl};
            OFS_STAT: s_next.rdata = {26'h000_0000, s_reg.irq_sync[1],
               frontend_reset_out_n, controller_reset_out_n,
               system_reset_out_n, s_reg.pg_sync[1], s_reg.pos_sync[1]};
            default: s_next.rdata = '0;
         endcase
      end
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_reg.pos_sync <= '0;
         s_reg.pg_sync <= '0;
         s_reg.irq_sync <= '0;
         s_reg.pg_prev <= 1'b0;
         s_reg.ctrl <= CTRL_RESET;
         s_reg.rdata <= '0;
      end
      else
         s_reg <= s_next;
   end
   assign prdata = s_reg.rdata;
   // ---------------------------------------------------------------
   // Timers
   // ---------------------------------------------------------------
   prs_timer u_sys (
      .pclk(pclk), .presetn(presetn), .trig(evt), .hold_more(1'b0),
      .active(sys_t));
   prs_timer u_ctl (
      .pclk(pclk), .presetn(presetn),
      .trig(evt && s_reg.ctrl[CTRL_CTL_AUTO]), .hold_more(1'b0),
      .active(ctl_t));
   prs_timer u_fe (
      .pclk(pclk), .presetn(presetn), .trig(evt),
      .hold_more(!s_reg.ctrl[CTRL_FE_REL]), .active(fe_t));
   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Power-on sense acts straight on the outputs for an immediate low.
   assign system_reset_out_n = power_on_sense && !pos_low &&
      s_reg.ctrl[CTRL_SYS_REL] && !sys_t;
   assign controller_reset_out_n = power_on_sense && !pos_low &&
      s_reg.ctrl[CTRL_CTL_REL] && !ctl_t;
   assign frontend_reset_out_n = power_on_sense && !pos_low &&
      s_reg.ctrl[CTRL_FE_REL] && !fe_t &&
      !s_reg.ctrl[CTRL_FE_FORCE];
   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   chk_sys_sense: assert property (@(posedge pclk) disable iff (!presetn)
      !power_on_sense |-> !system_reset_out_n)
      else $error("system reset high while sense low");
   chk_sys_release: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(system_reset_out_n) |-> s_reg.ctrl[CTRL_SYS_REL])
      else $error("system reset released without firmware");
   chk_ctl_sense: assert property (@(posedge pclk) disable iff (!presetn)
      !power_on_sense |-> !controller_reset_out_n)
      else $error("controller reset high while sense low");
   chk_fe_sense: assert property (@(posedge pclk) disable iff (!presetn)
      !power_on_sense |-> !frontend_reset_out_n)
      else $error("front-end reset high while sense low");
   chk_fe_force: assert property (@(posedge pclk) disable iff (!presetn)
      s_reg.ctrl[CTRL_FE_FORCE] |-> !frontend_reset_out_n)
      else $error("front-end force ignored");
   chk_fe_release: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(frontend_reset_out_n) |-> s_reg.ctrl[CTRL_FE_REL])
      else $error("front-end reset released without software");
   chk_sys_hold: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(sys_t) |-> sys_t [*8])
      else $error("system hold too short");
   chk_evt_delay: assert property (@(posedge pclk) disable iff (!presetn)
      pg_rise |-> ##[1:200] sys_t)
      else $error("system reset not asserted after event");
   chk_ctl_opt: assert property (
      @(posedge pclk) disable iff (!presetn)
      (evt && !(wr_en && paddr == OFS_CTRL) && !pos_low &&
      s_reg.pg_sync[1] && s_reg.ctrl[CTRL_CTL_REL] &&
      !s_reg.ctrl[CTRL_CTL_AUTO] && !ctl_t) |=>
      (controller_reset_out_n || !power_on_sense || pos_low || ctl_t))
      else $error("controller reset asserted while option off");
endmodule : prs_sequencer
`default_nettype wire

// ===== verification/prs_monitor.sv
// Voltage monitor model driving the sense, power-good and irq inputs.
// Assumes the bench calls its tasks from the pclk domain.
`timescale 1ns/1ns
`default_nettype none
module prs_monitor (
   input wire logic pclk,
   output logic power_on_sense,
   output logic power_good_in,
   output logic frontend_irq_in
);
   // ------------------------------------------------
   // Supply sequencing
   // ------------------------------------------------
   initial
   begin
      power_on_sense = 1'b0;
      power_good_in = 1'b0;
      frontend_irq_in = 1'b0;
   end
   task automatic up();
      @(posedge pclk) power_on_sense <= 1'b1;
      repeat (4) @(posedge pclk);
      power_good_in <= 1'b1;
   endtask : up
   // Power-good always falls before sense does.
   task automatic down();
      @(posedge pclk) power_good_in <= 1'b0;
      repeat (4) @(posedge pclk);
      power_on_sense <= 1'b0;
   endtask : down
   task automatic set_irq(input logic v);
      @(posedge pclk) frontend_irq_in <= v;
   endtask : set_irq
endmodule : prs_monitor
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking bench for the reset sequencer with an APB master.
// Assumes the monitor model and the default timer lengths.
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) \
      begin \
         n_errors++; \
         $display("wrong value at %0t: %h %h", $time, got, exp); \
      end \
   end
module testbench;
   import prs_pkg::*;
   // ------------------------------------------------
   // Signals, model and tasks
   // ------------------------------------------------
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic power_on_sense, power_good_in, frontend_irq_in;
   logic system_reset_out_n, controller_reset_out_n, frontend_reset_out_n;
   logic [2:0] e;
   int n_errors = 0, samples_checked = 0, seed = 32'hdf59_2c46;
   int m_sense = 0, m_pg = 0, m_rel = 0, m_force = 0, m_auto = 1;
   int m_hold = 0, m_irq = 0;
   prs_sequencer prs_sequencer_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .power_on_sense(power_on_sense), .power_good_in(power_good_in),
      .frontend_irq_in(frontend_irq_in),
      .system_reset_out_n(system_reset_out_n),
      .controller_reset_out_n(controller_reset_out_n),
      .frontend_reset_out_n(frontend_reset_out_n));
   prs_monitor prs_monitor_i (.pclk(pclk), .power_on_sense(power_on_sense),
      .power_good_in(power_good_in), .frontend_irq_in(frontend_irq_in));
   function automatic logic [2:0] exp_outs();
      logic s, c, f;
      s = m_sense && m_rel[0] && !m_hold;
      c = m_sense && m_rel[1] && !(m_hold && m_auto);
      f = m_sense && m_rel[2] && !m_force && !m_hold;
      return {f, c, s};
   endfunction : exp_outs
   task automatic finish_test();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   task automatic apb(input logic w, input logic [11:0] a, input int d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= 32'(d);
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 16; k++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k == 16)
      begin
         n_errors++;
         finish_test();
      end
   endtask : apb
   task automatic wr_ctrl(input int v);
      apb(1'b1, OFS_CTRL, ($random(seed) & 32'hffff_ffe0) | v);
   endtask : wr_ctrl
   task automatic check_outs();
      @(negedge pclk);
      e = exp_outs();
      `CHK(system_reset_out_n, e[0])
      `CHK(controller_reset_out_n, e[1])
      `CHK(frontend_reset_out_n, e[2])
   endtask : check_outs
   task automatic check_stat();
      apb(1'b0, OFS_STAT, 0);
      `CHK(rd[5:0], {1'(m_irq), exp_outs(), 1'(m_pg), 1'(m_sense)})
   endtask : check_stat
   // ------------------------------------------------
   // Clock and main sequence
   // ------------------------------------------------
   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      check_outs();
      apb(1'b0, OFS_CTRL, 0);
      `CHK(rd, 32'h0000_0008)
      apb(1'b0, 12'h0_010, 0);
      `CHK({err, rd}, 33'h0_0000_0000 | 33'h1_0000_0000)
      $display("test reset done");
      prs_monitor_i.up();
      m_sense = 1;
      m_pg = 1;
      m_hold = 1;
      repeat (200) check_outs();
      wr_ctrl(32'h0000_000f);
      m_rel = 7;
      repeat (48800) @(posedge pclk);
      check_outs();
      repeat (1500) @(posedge pclk);
      m_hold = 0;
      check_outs();
      check_stat();
      $display("test power_up done");
      prs_monitor_i.set_irq(1'b1);
      m_irq = 1;
      wr_ctrl(32'h0000_001f);
      m_force = 1;
      check_outs();
      check_stat();
      wr_ctrl(32'h0000_0007);
      m_force = 0;
      m_auto = 0;
      check_outs();
      $display("test force done");
      apb(1'b1, OFS_EVENT, 1);
      m_rel = 3;
      check_outs();
      wr_ctrl(32'h0000_0007);
      m_rel = 7;
      repeat (100)
      begin
         @(negedge pclk);
         `CHK(system_reset_out_n, 1'b1)
         `CHK(controller_reset_out_n, 1'b1)
      end
      repeat (150) @(posedge pclk);
      m_hold = 1;
      repeat (200) check_outs();
      $display("test event done");
      prs_monitor_i.down();
      m_sense = 0;
      m_pg = 0;
      m_rel = 0;
      repeat (50) check_outs();
      $display("test power_down done");
      finish_test();
   end
endmodule : testbench
`default_nettype wire
